// >>> include/fiac_pkg.sv
// Package for flash in-application access control: SFR addresses, flash map, timing.
// Assumes an 8051-style core on the same clock driving SFR and MOVX/MOVC strobes.
`default_nettype none
package fiac_pkg;
  // ----------------------------------------------------------------
  // SFR addresses and command values
  // ----------------------------------------------------------------
  localparam logic [7:0] FIAC_SFR_SOFT_COMMAND     = 8'h97;
  localparam logic [7:0] FIAC_SFR_FLASH_WRITE_GATE = 8'hC9;
  localparam logic [7:0] FIAC_SFR_CONFIG_WORD_LOW  = 8'hF7;
  localparam logic [7:0] FIAC_UNLOCK_KEY           = 8'h65;
  localparam logic [7:0] FIAC_WRITE_KEY            = 8'h47;
  localparam int         FIAC_UNLOCK_BIT           = 0;
  localparam int         FIAC_WRITE_EN_BIT         = 7;
  localparam int         FIAC_LOCK_BIT             = 1;
  // ----------------------------------------------------------------
  // Flash and data map
  // ----------------------------------------------------------------
  localparam logic [15:0] FIAC_LOCK_LAST   = 16'h01FF;
  localparam logic [15:0] FIAC_WIDE_LAST   = 16'h3EFF;
  localparam logic [15:0] FIAC_FREE_LAST   = 16'h3FFB;
  localparam logic [15:0] FIAC_SPARE_LAST  = 16'h3FFE;
  localparam logic [15:0] FIAC_CFG_HIGH    = 16'h3FFF;
  localparam logic [15:0] FIAC_CFG_LOW     = 16'h3FFE;
  localparam logic [15:0] FIAC_EXTERNAL_DATA_RAM_FIRST  = 16'hFE00;
  localparam logic [7:0]  FIAC_ZERO_BYTE   = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FIAC_CLK_MHZ        = 100;
  localparam int FIAC_WRITE_TIME_US  = 200;
  localparam int FIAC_WRITE_CYCLES   = FIAC_WRITE_TIME_US * FIAC_CLK_MHZ;
  typedef enum logic [1:0] {
    FIAC_IDLE  = 2'b00,
    FIAC_LOAD  = 2'b01,
    FIAC_PROG  = 2'b10
  } fiac_state_e;
endpackage
`default_nettype wire

// >>> include/fiac_flash_if.sv
// Interface between access control and flash array port.
// Assumes one clock domain; array is owned by the flash module.
`default_nettype none
interface fiac_flash_if;
  logic [13:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic [7:0]  rdata;
  logic [15:0] cfg;
  modport ctrl  (output addr, output wdata, output wr, input rdata, input cfg);
  modport array (input addr, input wdata, input wr, output rdata, output cfg);
endinterface
`default_nettype wire

// >>> logic/fiac_flash_array.sv
// Flash array model: byte-programmable storage, combinational read.
// Assumes writes are issued only by the access controller.
`default_nettype none
module fiac_flash_array
  import fiac_pkg::*;
#(
  parameter int DEPTH = 16384
) (
  input  wire logic core_clk,
  fiac_flash_if.array fl
);
  // Erased flash reads zero in this model
  logic [7:0] mem [DEPTH] = '{default: FIAC_ZERO_BYTE};
  // ----------------------------------------------------------------
  // Byte program, no erase needed
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (fl.wr) begin
      mem[fl.addr] <= fl.wdata;
    end
  end
  assign fl.rdata = mem[fl.addr];
  assign fl.cfg   = {mem[FIAC_CFG_HIGH[13:0]], mem[FIAC_CFG_LOW[13:0]]};
endmodule
`default_nettype wire

// >>> logic/fiac_top.sv
// Flash in-application access control: region gating, unlock flags, write stall.
// Assumes the core holds its request while stall is high and samples data a cycle on.
`default_nettype none
module fiac_top
  import fiac_pkg::*;
#(
  parameter int WRITE_CYCLES = FIAC_WRITE_CYCLES,
  parameter int EXTERNAL_DATA_RAM_DEPTH   = 512
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        movc_rd,
  input  wire logic        movx_rd,
  input  wire logic        movx_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  acc_data,
  output logic      [7:0]  mem_rdata,
  output logic             access_refused,
  output logic             cpu_stall,
  input  wire logic        irq_in,
  output logic             irq_pending,
  output logic             code_read_lock,
  output logic             wide_write_unlock,
  output logic             flash_write_enable,
  output logic      [7:0]  config_word_low
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  fiac_flash_if fl ();
  fiac_flash_array u_array (
    .core_clk (core_clk),
    .fl       (fl)
  );

  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FIAC_REG_LOCK  = 3'b000,
    FIAC_REG_WIDE  = 3'b001,
    FIAC_REG_FREE  = 3'b010,
    FIAC_REG_SPARE = 3'b011,
    FIAC_REG_CFGH  = 3'b100,
    FIAC_REG_EXTERNAL_DATA_RAM  = 3'b101,
    FIAC_REG_NONE  = 3'b110
  } fiac_region_e;

  // One decode shared by read, write and refusal paths
  function automatic fiac_region_e region_of(input logic [15:0] a);
    fiac_region_e r;
    r = FIAC_REG_NONE;
    if (a >= FIAC_EXTERNAL_DATA_RAM_FIRST) begin
      r = FIAC_REG_EXTERNAL_DATA_RAM;
    end else if (a <= FIAC_LOCK_LAST) begin
      r = FIAC_REG_LOCK;
    end else if (a <= FIAC_WIDE_LAST) begin
      r = FIAC_REG_WIDE;
    end else if (a <= FIAC_FREE_LAST) begin
      r = FIAC_REG_FREE;
    end else if (a <= FIAC_SPARE_LAST) begin
      r = FIAC_REG_SPARE;
    end else if (a == FIAC_CFG_HIGH) begin
      r = FIAC_REG_CFGH;
    end
    return r;
  endfunction

  function automatic logic movx_ok(input fiac_region_e r, input logic lock, input logic unl);
    logic ok;
    ok = 1'b0;
    case (r)
      FIAC_REG_LOCK:  ok = !lock && unl;
      FIAC_REG_WIDE:  ok = unl;
      FIAC_REG_FREE:  ok = 1'b1;
      FIAC_REG_SPARE: ok = unl;
      FIAC_REG_CFGH:  ok = 1'b0;
      FIAC_REG_EXTERNAL_DATA_RAM:  ok = 1'b1;
      default:        ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic movc_ok(input fiac_region_e r, input logic lock);
    logic ok;
    ok = 1'b0;
    case (r)
      FIAC_REG_LOCK:  ok = !lock;
      FIAC_REG_WIDE,
      FIAC_REG_FREE,
      FIAC_REG_SPARE,
      FIAC_REG_CFGH:  ok = 1'b1;
      default:        ok = 1'b0;
    endcase
    return ok;
  endfunction

  fiac_region_e region;
  logic         is_external_data_ram;
  logic         is_flash;
  logic         movx_allowed;
  assign region       = region_of(mem_addr);
  assign is_external_data_ram      = region == FIAC_REG_EXTERNAL_DATA_RAM;
  assign is_flash     = mem_addr <= FIAC_CFG_HIGH;
  assign movx_allowed = movx_ok(region, code_read_lock, wide_write_unlock);

  // ----------------------------------------------------------------
  // SFR write decode
  // ----------------------------------------------------------------
  logic wr_soft_command;
  logic wr_write_gate;
  logic wr_config_low;
  assign wr_soft_command = sfr_wr && sfr_addr == FIAC_SFR_SOFT_COMMAND;
  assign wr_write_gate   = sfr_wr && sfr_addr == FIAC_SFR_FLASH_WRITE_GATE;
  assign wr_config_low   = sfr_wr && sfr_addr == FIAC_SFR_CONFIG_WORD_LOW;

  // ----------------------------------------------------------------
  // Configuration load after reset
  // ----------------------------------------------------------------
  // High configuration byte sits above the low one in the loaded pair
  localparam int CFG_HIGH_LSB = 8;
  logic cfg_loaded;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_loaded      <= 1'b0;
      code_read_lock  <= 1'b1;
      config_word_low <= FIAC_ZERO_BYTE;
    end else if (!cfg_loaded) begin
      cfg_loaded      <= 1'b1;
      code_read_lock  <= fl.cfg[CFG_HIGH_LSB + FIAC_LOCK_BIT];
      config_word_low <= fl.cfg[7:0];
    end else if (wr_config_low) begin
      config_word_low <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Unlock and write enable flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wide_write_unlock <= 1'b0;
    end else if (wr_soft_command) begin
      wide_write_unlock <= (sfr_wdata == FIAC_UNLOCK_KEY);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_write_enable <= 1'b0;
    end else if (wr_write_gate) begin
      flash_write_enable <= (sfr_wdata == FIAC_WRITE_KEY);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= FIAC_ZERO_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= FIAC_ZERO_BYTE;
      case (sfr_addr)
        FIAC_SFR_SOFT_COMMAND:     sfr_rdata[FIAC_UNLOCK_BIT] <= wide_write_unlock;
        FIAC_SFR_FLASH_WRITE_GATE: sfr_rdata[FIAC_WRITE_EN_BIT] <= flash_write_enable;
        FIAC_SFR_CONFIG_WORD_LOW:  sfr_rdata <= config_word_low;
        default:                   sfr_rdata <= FIAC_ZERO_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // External data RAM
  // ----------------------------------------------------------------
  logic [7:0] external_data_ram [EXTERNAL_DATA_RAM_DEPTH];
  logic [8:0] external_data_ram_idx;
  assign external_data_ram_idx = mem_addr[8:0];
  always_ff @(posedge core_clk) begin
    if (movx_wr && is_external_data_ram && cpu_stall == 1'b0) begin
      external_data_ram[external_data_ram_idx] <= acc_data;
    end
  end

  // ----------------------------------------------------------------
  // Flash write sequencer
  // ----------------------------------------------------------------
  fiac_state_e state;
  fiac_state_e next_state;
  logic [31:0] wait_cnt;
  logic [13:0] prog_addr;
  logic [7:0]  prog_data;
  logic        write_req;
  logic        write_go;
  logic        prog_last;
  // Refused writes never raise write_req, so they cannot stall
  assign write_req = movx_wr && is_flash && mem_addr <= FIAC_SPARE_LAST
                     && flash_write_enable && movx_allowed;
  // Only an idle sequencer takes a request; the held strobe must not restart it
  assign write_go  = write_req && state == FIAC_IDLE;
  assign prog_last = wait_cnt == 32'(WRITE_CYCLES - 1);

  always_comb begin
    next_state = state;
    case (state)
      FIAC_IDLE: if (write_go) next_state = FIAC_PROG;
      FIAC_PROG: if (prog_last) next_state = FIAC_LOAD;
      FIAC_LOAD: next_state = FIAC_IDLE;
      default:   next_state = FIAC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= FIAC_IDLE;
      wait_cnt  <= '0;
      prog_addr <= '0;
      prog_data <= FIAC_ZERO_BYTE;
    end else begin
      state <= next_state;
      if (state == FIAC_IDLE && write_go) begin
        prog_addr <= mem_addr[13:0];
        prog_data <= acc_data;
        wait_cnt  <= '0;
      end else if (state == FIAC_PROG) begin
        wait_cnt <= wait_cnt + 32'd1;
      end
    end
  end

  // Stall covers the request cycle too, so the core holds its MOVX
  // Stall drops in the load cycle, so the core retires the MOVX at that edge
  assign cpu_stall = write_go || state == FIAC_PROG;

  // Programming happens once, at the end of the write time
  assign fl.wr    = state == FIAC_LOAD;
  assign fl.addr  = fl.wr ? prog_addr : mem_addr[13:0];
  assign fl.wdata = prog_data;

  // ----------------------------------------------------------------
  // Interrupt hold during stall
  // ----------------------------------------------------------------
  logic irq_held;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_held <= 1'b0;
    end else if (cpu_stall && irq_in) begin
      irq_held <= 1'b1;
    end else if (!cpu_stall) begin
      irq_held <= 1'b0;
    end
  end
  assign irq_pending = !cpu_stall && (irq_in || irq_held);

  // ----------------------------------------------------------------
  // Read path, zero wait
  // ----------------------------------------------------------------
  logic rd_ok;
  logic rd_any;
  logic refused_rd;
  logic refused_wr;
  assign rd_any = movx_rd || movc_rd;
  always_comb begin
    rd_ok = 1'b0;
    if (movx_rd) begin
      rd_ok = movx_allowed;
    end else if (movc_rd) begin
      rd_ok = movc_ok(region, code_read_lock);
    end
  end
  assign refused_rd = rd_any && !rd_ok;
  // Writes outside flash go to the RAM window or nowhere, so only flash ones report
  assign refused_wr = movx_wr && is_flash && !write_req;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      access_refused <= 1'b0;
    end else begin
      access_refused <= refused_rd || refused_wr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= FIAC_ZERO_BYTE;
    end else if (movx_rd && is_external_data_ram) begin
      mem_rdata <= external_data_ram[external_data_ram_idx];
    end else if (rd_any && rd_ok) begin
      mem_rdata <= fl.rdata;
    end else if (rd_any) begin
      mem_rdata <= FIAC_ZERO_BYTE;
    end
  end
endmodule
`default_nettype wire

// >>> tb/fiac_top_sva.sv
// Checker for fiac_top: key registers, region gating, write stall.
// Assumes a small WRITE_CYCLES in simulation; bound sits at file foot.
`default_nettype none
module fiac_top_sva
  import fiac_pkg::*;
#(
  parameter int WRITE_CYCLES = FIAC_WRITE_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        movx_wr,
  input wire logic [15:0] mem_addr,
  input wire logic        access_refused,
  input wire logic        cpu_stall,
  input wire logic        irq_pending,
  input wire logic        wide_write_unlock,
  input wire logic        flash_write_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] stall_cnt;
  // Counter, since the stall is too long for a repetition
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stall_cnt <= 32'h0;
    end else begin
      stall_cnt <= cpu_stall ? stall_cnt + 32'h1 : 32'h0;
    end
  end
  property p_unlock;
    sfr_wr && sfr_addr == FIAC_SFR_SOFT_COMMAND
      |=> wide_write_unlock == ($past(sfr_wdata) == FIAC_UNLOCK_KEY);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock flag wrong");
  property p_wen;
    sfr_wr && sfr_addr == FIAC_SFR_FLASH_WRITE_GATE
      |=> flash_write_enable == ($past(sfr_wdata) == FIAC_WRITE_KEY);
  endproperty
  a_wen: assert property (p_wen) else $error("write enable wrong");
  property p_wide;
    $rose(movx_wr) && !wide_write_unlock && mem_addr > FIAC_LOCK_LAST
      && mem_addr <= FIAC_WIDE_LAST |-> !cpu_stall ##1 access_refused;
  endproperty
  a_wide: assert property (p_wide) else $error("wide write not refused");
  property p_gate;
    $rose(movx_wr) && !flash_write_enable && mem_addr <= FIAC_SPARE_LAST
      |-> !cpu_stall ##1 access_refused;
  endproperty
  a_gate: assert property (p_gate) else $error("disabled write taken");
  property p_cfgh;
    $rose(movx_wr) && mem_addr == FIAC_CFG_HIGH |-> !cpu_stall ##1 access_refused;
  endproperty
  a_cfgh: assert property (p_cfgh) else $error("top config written");
  property p_free;
    $rose(movx_wr) && flash_write_enable && mem_addr > FIAC_WIDE_LAST
      && mem_addr <= FIAC_FREE_LAST |-> cpu_stall;
  endproperty
  a_free: assert property (p_free) else $error("free area write lost");
  property p_stall;
    $fell(cpu_stall) |-> stall_cnt >= WRITE_CYCLES && stall_cnt <= WRITE_CYCLES + 3;
  endproperty
  a_stall: assert property (p_stall) else $error("stall length wrong");
  property p_irq;
    cpu_stall |-> !irq_pending;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt shown in stall");
  c_write: cover property ($rose(cpu_stall));
  c_refuse: cover property ($rose(access_refused));
  c_irq: cover property ($fell(cpu_stall) && irq_pending);
endmodule
bind fiac_top fiac_top_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_fiac_top_sva (
  .core_clk, .nrst, .sfr_wr, .sfr_addr, .sfr_wdata, .movx_wr, .mem_addr, .access_refused,
  .cpu_stall, .irq_pending, .wide_write_unlock, .flash_write_enable);
`default_nettype wire

// >>> tb/fiac_cpu_model.sv
// CPU core model: one SFR or memory request at a time.
// Assumes cpu_stall is combinational; a held write ends at an unstalled edge.
`default_nettype none
module fiac_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        cpu_stall,
  output logic             sfr_wr,
  output logic             sfr_rd,
  output logic             movc_rd,
  output logic             movx_rd,
  output logic             movx_wr,
  output logic      [7:0]  sfr_addr,
  output logic      [7:0]  sfr_wdata,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  acc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sfr_wr, sfr_rd, movc_rd, movx_rd, movx_wr} = 5'h00;
    {sfr_addr, sfr_wdata, mem_addr, acc_data} = 40'h0;
  end
  task automatic req(input logic [4:0] k, input logic [15:0] a, input logic [7:0] d,
                     output logic hung);
    int n = 0;
    @(posedge core_clk);
    {sfr_wr, sfr_rd, movc_rd, movx_rd, movx_wr} <= k;
    sfr_addr <= a[7:0];
    sfr_wdata <= d;
    mem_addr <= a;
    acc_data <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (cpu_stall && n < 64);
    hung = cpu_stall;
    {sfr_wr, sfr_rd, movc_rd, movx_rd, movx_wr} <= 5'h00;
    // Memory address and data flip on release, so stale values never look valid
    mem_addr <= ~a;
    acc_data <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> tb/flash_iap_access_control_tb.sv
// Bench for fiac_top: key registers, gating, write stall, external RAM.
// Assumes flash starts all zero and the CPU model drives every request.
`default_nettype none
module flash_iap_access_control_tb;
  import fiac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] SW = 5'h10, SR = 5'h08, MC = 5'h04, MR = 5'h02, MW = 5'h01;
  logic core_clk, nrst, irq_in, sfr_wr, sfr_rd, movc_rd, movx_rd, movx_wr, hung, rf;
  logic cpu_stall, access_refused, irq_pending, code_read_lock, wide_write_unlock;
  logic flash_write_enable, pend = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc_data, mem_rdata, config_word_low, v;
  logic [15:0] mem_addr;
  logic [31:0] rnd;
  logic [10:0] exp_q[$];
  logic [7:0] gv[5];
  logic [15:0] ga[5] = '{16'h0010, 16'h1234, 16'h3F10, 16'h3FFD, 16'h3FFF};
  int num_errors = 0, samples_checked = 0;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  fiac_top #(.WRITE_CYCLES(8)) u_fiac_top (.core_clk, .nrst, .sfr_wr, .sfr_rd, .sfr_addr,
    .sfr_wdata, .sfr_rdata, .movc_rd, .movx_rd, .movx_wr, .mem_addr, .acc_data, .mem_rdata,
    .access_refused, .cpu_stall, .irq_in, .irq_pending, .code_read_lock, .wide_write_unlock,
    .flash_write_enable, .config_word_low);
  fiac_cpu_model u_fiac_cpu_model (.core_clk, .cpu_stall, .sfr_wr, .sfr_rd, .movc_rd,
    .movx_rd, .movx_wr, .sfr_addr, .sfr_wdata, .mem_addr, .acc_data);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [4:0] k, input logic [15:0] a, input logic [7:0] d,
                    input logic r, input logic [7:0] ed);
    if (k != SW) exp_q.push_back({k == SR, k != MW, r, ed});
    u_fiac_cpu_model.req(k, a, d, hung);
    if (hung) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic do_reset();
    @(posedge core_clk) nrst <= 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask
  // ----------------------------------------
  // Result monitor: oldest note per answer
  // ----------------------------------------
  always @(posedge core_clk) begin
    logic [10:0] e;
    if (pend) begin
      e = exp_q.pop_front();
      chk(e[10] ? "sfr_rdata" : "mem_result", e[8:0],
          e[10] ? {1'b0, sfr_rdata} : {access_refused, e[9] ? mem_rdata : e[7:0]});
    end
    pend = sfr_rd | movc_rd | movx_rd | (movx_wr & ~cpu_stall);
  end
  initial begin
    nrst = 1'b0;
    irq_in = 1'b0;
    rnd = 32'h1F;
    do_reset();
    chk("code_read_lock", 9'h000, {8'h00, code_read_lock});
    chk("config_word_low", 9'h000, {1'b0, config_word_low});
    op(SR, 16'h0097, 8'h00, 1'b0, 8'h00);
    op(SR, 16'h00C9, 8'h00, 1'b0, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      v = i[0] ? rnd[7:0] : FIAC_UNLOCK_KEY;
      op(SW, 16'h0097, v, 1'b0, 8'h00);
      op(SR, 16'h0097, 8'h00, 1'b0, {7'h00, v == FIAC_UNLOCK_KEY});
      v = i[0] ? rnd[15:8] : FIAC_WRITE_KEY;
      op(SW, 16'h00C9, v, 1'b0, 8'h00);
      op(SR, 16'h00C9, 8'h00, 1'b0, {v == FIAC_WRITE_KEY, 7'h00});
      op(SW, 16'h00F7, rnd[23:16], 1'b0, 8'h00);
      op(SR, 16'h00F7, 8'h00, 1'b0, rnd[23:16]);
    end
    $display("test key registers done");
    rnd = xs(rnd);
    gv = '{rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24], 8'h00};
    op(SW, 16'h00C9, FIAC_WRITE_KEY, 1'b0, 8'h00);
    op(SW, 16'h0097, 8'h00, 1'b0, 8'h00);
    op(MW, 16'h1234, gv[1], 1'b1, 8'h00);
    fork
      op(MW, 16'h3F10, gv[2], 1'b0, 8'h00);
      begin
        repeat (2) @(posedge core_clk);
        irq_in <= 1'b1;
        @(posedge core_clk) irq_in <= 1'b0;
        for (int t = 0; t < 64 && cpu_stall; t++) @(negedge core_clk);
        chk("irq_pending", 9'h001, {8'h00, irq_pending});
      end
    join
    op(SW, 16'h0097, FIAC_UNLOCK_KEY, 1'b0, 8'h00);
    op(MW, 16'h0010, gv[0], 1'b0, 8'h00);
    op(MW, 16'h3FFD, gv[3], 1'b0, 8'h00);
    op(MW, 16'h3FFF, 8'h5A, 1'b1, 8'h00);
    op(MW, 16'h1234, gv[1], 1'b0, 8'h00);
    op(SW, 16'h00C9, 8'h00, 1'b0, 8'h00);
    op(MW, 16'h3F20, 8'hA5, 1'b1, 8'h00);
    $display("test flash writes done");
    for (int u = 0; u < 2; u++) begin
      op(SW, 16'h0097, u[0] ? FIAC_UNLOCK_KEY : 8'h00, 1'b0, 8'h00);
      for (int j = 0; j < 5; j++) begin
        op(MC, ga[j], 8'h00, 1'b0, gv[j]);
        rf = (j == 4) || (u == 0 && j != 2);
        if (j != 1) op(MR, ga[j], 8'h00, rf, rf ? 8'h00 : gv[j]);
      end
    end
    $display("test read gating done");
    op(MW, 16'hFE00, gv[2], 1'b0, 8'h00);
    op(MW, 16'hFFFF, gv[3], 1'b0, 8'h00);
    op(MR, 16'hFE00, 8'h00, 1'b0, gv[2]);
    op(MR, 16'hFFFF, 8'h00, 1'b0, gv[3]);
    op(SW, 16'h00C9, FIAC_WRITE_KEY, 1'b0, 8'h00);
    do_reset();
    op(SR, 16'h0097, 8'h00, 1'b0, 8'h00);
    op(SR, 16'h00C9, 8'h00, 1'b0, 8'h00);
    $display("test second reset done");
    repeat (2) @(posedge core_clk);
    give_verdict();
  end
endmodule
`default_nettype wire
